// File: rtl/csw_map.svh
`ifndef CSW_MAP_SVH
`define CSW_MAP_SVH
// Widths
`define CSW_DEV_W 16
`define CSW_RATE_W 12
`define CSW_ID_W 11
`define CSW_OFS_W 8
`define CSW_CNT_W 4
// Reset values
`define CSW_RATE_RST 12'h000
`define CSW_WSV_RST 3'h0
// Wakeup status vector codes
`define CSW_WSV_RECEIVED_HEADER 3'h3
`define CSW_WSV_RECEIVED_WUP 3'h4
// Sync frame table depth
`define CSW_SYNC_MAX 15
`endif

// File: rtl/csw_pkg.sv
package csw_pkg;
  // Protocol operation state seen by this block
  typedef enum logic [2:0] {
    POC_READY = 3'b000,
    POC_WAKEUP_LISTEN = 3'b001,
    POC_STARTUP = 3'b010,
    POC_NORMAL_ACTIVE = 3'b011,
    POC_NORMAL_PASSIVE = 3'b100,
    POC_HALT = 3'b101
  } poc_state_t;

  // One frame report from the frame decoder
  typedef struct packed {
    logic valid;
    logic sync;
    logic channel_b;
    logic odd_cycle;
    logic [10:0] frame_id;
    logic [15:0] deviation;
  } frame_rpt_t;

  // Configuration bundle
  typedef struct packed {
    logic allow_halt_due_to_clock;
    logic [3:0] max_without_corr_passive;
    logic [3:0] max_without_corr_fatal;
    logic [7:0] micro_init_offset_a;
    logic [7:0] micro_init_offset_b;
  } csw_cfg_t;
endpackage : csw_pkg

// File: rtl/wakeup_detect.sv
`include "csw_map.svh"
// Per-channel wakeup pattern detector: pattern every second symbol
module wakeup_detect
  import csw_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic symbol_seen,
  input wire logic idle_seen,
  output logic pattern_found
);
  logic armed_reg; // One symbol held, waiting for its partner
  logic idle_ok_reg; // Proper idle since the last symbol

  // Idle tracking between symbols
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_ok_reg <= 1'b0;
    end else if (symbol_seen) begin
      idle_ok_reg <= 1'b0;
    end else if (idle_seen) begin
      idle_ok_reg <= 1'b1;
    end
  end

  // Pair symbols; disarm after a pattern so the next one needs two more
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
      pattern_found <= 1'b0;
    end else begin
      pattern_found <= 1'b0;
      if (symbol_seen) begin
        if (armed_reg && idle_ok_reg) begin
          pattern_found <= 1'b1;
          armed_reg <= 1'b0;
        end else begin
          armed_reg <= 1'b1;
        end
      end
    end
  end
endmodule : wakeup_detect

// File: rtl/clock_sync_wakeup.sv
// Overview of operation
// - Sync frame counted despite later non-sync frame
// - Wakeup pattern only on every second symbol
// - Missing term keeps last rate correction
// - Missing term sets flag, passive/halt/abort
// - Stay active below passive cycle limit
// - Allow-halt config selects halt on failure
// - Count sync frames, pair odd with even
// - No pair sets both flags; pair prevents
// - Late secondary reference never zeroes deviation
// - Initial rate from offset, zero offset fine
// - Wakeup pattern in listen: ready, status update
`include "csw_map.svh"
module clock_sync_wakeup
  import csw_pkg::*;
#(
  parameter int SYNC_MAX = `CSW_SYNC_MAX
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire frame_rpt_t frame_rpt,
  input wire logic slot_start,
  input wire logic action_point,
  input wire logic strp_seen,
  input wire logic [15:0] strp_deviation,
  input wire logic cycle_end,
  input wire logic integrating,
  input wire csw_cfg_t cfg,
  input wire logic [1:0] wus_seen,
  input wire logic [1:0] idle_seen,
  input wire logic cmd_wakeup_listen,
  input wire logic cmd_startup,
  input wire logic cmd_ready,
  input wire logic clear_mrc,
  input wire logic clear_ccf,
  input wire logic clear_wst,
  input wire logic [1:0] clear_wup,
  output logic missing_rate_corr_flag,
  output logic clock_corr_fail_flag,
  output logic wakeup_status_flag,
  output logic [1:0] wakeup_pattern_flag_per_channel,
  output logic [2:0] wakeup_status_vector,
  output poc_state_t poc_state,
  output logic startup_abort,
  output logic [11:0] rate_correction,
  output logic [15:0] offset_correction,
  output logic [3:0] sync_count,
  output logic flag_event
);
  // Even-cycle sync table
  logic [10:0] even_id_reg [0:SYNC_MAX-1];
  logic [15:0] even_dev_reg [0:SYNC_MAX-1];
  logic [3:0] even_cnt_reg; // Even sync entries
  logic [3:0] odd_new_reg; // Odd frames without even partner
  logic [3:0] pair_cnt_reg; // Matched pairs
  logic signed [19:0] pair_sum_reg; // Sum of pair deviation differences
  logic slot_has_sync_reg; // Sync already accepted in this slot
  logic signed [15:0] slot_dev_reg; // Deviation kept for this slot
  logic [3:0] no_corr_cnt_reg; // Double cycles without correction
  logic [1:0] wup_pulse; // Per channel pattern pulses
  logic miss_term; // Double cycle produced no pair
  logic match_hit; // Odd sync frame found an even partner
  logic [3:0] match_idx;
  logic signed [15:0] match_dev;

  // Even-table search for the odd sync frame
  function automatic logic [4:0] find_even(input logic [10:0] id,
                                            input logic [3:0] cnt);
    logic [4:0] res;
    res = 5'h1F;
    for (int i = SYNC_MAX - 1; i >= 0; i--) begin
      if (4'(i) < cnt && even_id_reg[i] == id) begin
        res = {1'b0, 4'(i)};
      end
    end
    return res;
  endfunction : find_even

  // Initial rate from the microtick offset, zero offset allowed
  function automatic logic [11:0] init_rate(input logic [7:0] ofs_a,
                                            input logic [7:0] ofs_b);
    logic [7:0] big;
    big = (ofs_a > ofs_b) ? ofs_a : ofs_b;
    return {4'h0, big} + 12'h001;
  endfunction : init_rate

  // Match lookup
  always_comb begin
    logic [4:0] r;
    r = find_even(frame_rpt.frame_id, even_cnt_reg);
    match_hit = ~r[4];
    match_idx = r[3:0];
    match_dev = even_dev_reg[match_idx];
  end

  assign miss_term = (pair_cnt_reg == 4'h0);

  // Per-slot sync capture; later frames in the slot cannot erase it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_has_sync_reg <= 1'b0;
      slot_dev_reg <= 16'h0000;
    end else if (slot_start) begin
      slot_has_sync_reg <= 1'b0;
    end else if (frame_rpt.valid && frame_rpt.sync && !slot_has_sync_reg) begin
      slot_has_sync_reg <= 1'b1;
      slot_dev_reg <= frame_rpt.deviation;
    end else if (strp_seen && action_point && !slot_has_sync_reg) begin
      slot_dev_reg <= strp_deviation; // Only used if no sync yet
    end
  end

  // Sync table and pairing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      even_cnt_reg <= 4'h0;
      odd_new_reg <= 4'h0;
      pair_cnt_reg <= 4'h0;
      pair_sum_reg <= 20'sh0_0000;
      for (int i = 0; i < SYNC_MAX; i++) begin
        even_id_reg[i] <= 11'h000;
        even_dev_reg[i] <= 16'h0000;
      end
    end else if (cycle_end && frame_rpt.odd_cycle) begin
      even_cnt_reg <= 4'h0;
      odd_new_reg <= 4'h0;
      pair_cnt_reg <= 4'h0;
      pair_sum_reg <= 20'sh0_0000;
    end else if (frame_rpt.valid && frame_rpt.sync && !slot_has_sync_reg) begin
      if (!frame_rpt.odd_cycle) begin
        if (32'(even_cnt_reg) < SYNC_MAX) begin
          even_id_reg[even_cnt_reg] <= frame_rpt.frame_id;
          even_dev_reg[even_cnt_reg] <= frame_rpt.deviation;
          even_cnt_reg <= even_cnt_reg + 4'h1;
        end
      end else if (match_hit) begin
        // Pairs accepted regardless of distinct-frame overflow
        pair_cnt_reg <= pair_cnt_reg + 4'h1;
        pair_sum_reg <= pair_sum_reg
          + 20'(signed'(frame_rpt.deviation)) - 20'(signed'(match_dev));
      end else if (odd_new_reg != 4'hF) begin
        odd_new_reg <= odd_new_reg + 4'h1;
      end
    end
  end

  // Distinct sync frames seen this double cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_count <= 4'h0;
    end else begin
      sync_count <= 4'(even_cnt_reg + odd_new_reg);
    end
  end

  // Rate and offset correction at the double-cycle end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_correction <= `CSW_RATE_RST;
      offset_correction <= 16'h0000;
    end else if (cmd_startup && integrating) begin
      rate_correction <= init_rate(cfg.micro_init_offset_a,
                                   cfg.micro_init_offset_b);
    end else if (cycle_end && frame_rpt.odd_cycle) begin
      if (!miss_term) begin
        rate_correction <= pair_sum_reg[11:0];
        offset_correction <= slot_dev_reg;
      end
      // Missing term: last value kept, never zero
    end
  end

  // Missing-correction counter and state decision
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      no_corr_cnt_reg <= 4'h0;
      poc_state <= POC_READY;
      startup_abort <= 1'b0;
    end else begin
      startup_abort <= 1'b0;
      if (cmd_ready) begin
        poc_state <= POC_READY;
      end else if (poc_state == POC_WAKEUP_LISTEN && |wup_pulse) begin
        poc_state <= POC_READY;
      end else if (cmd_wakeup_listen && poc_state == POC_READY) begin
        poc_state <= POC_WAKEUP_LISTEN;
      end else if (cmd_startup && poc_state == POC_READY) begin
        poc_state <= POC_STARTUP;
        no_corr_cnt_reg <= 4'h0;
      end else if (cycle_end && frame_rpt.odd_cycle) begin
        if (!miss_term) begin
          no_corr_cnt_reg <= 4'h0;
          if (poc_state == POC_STARTUP) begin
            poc_state <= POC_NORMAL_ACTIVE;
          end
        end else begin
          no_corr_cnt_reg <= no_corr_cnt_reg + {3'h0, no_corr_cnt_reg != 4'hF};
          unique case (poc_state)
            POC_STARTUP: begin
              poc_state <= POC_READY;
              startup_abort <= 1'b1;
            end
            POC_NORMAL_ACTIVE: begin
              if (no_corr_cnt_reg + 4'h1 >= cfg.max_without_corr_passive) begin
                poc_state <= cfg.allow_halt_due_to_clock ? POC_HALT
                                                         : POC_NORMAL_PASSIVE;
              end
            end
            POC_NORMAL_PASSIVE: begin
              if (no_corr_cnt_reg + 4'h1 >= cfg.max_without_corr_fatal) begin
                poc_state <= POC_HALT;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Clock flags, set wins over clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      missing_rate_corr_flag <= 1'b0;
      clock_corr_fail_flag <= 1'b0;
    end else begin
      if (cycle_end && frame_rpt.odd_cycle && miss_term) begin
        missing_rate_corr_flag <= 1'b1;
        clock_corr_fail_flag <= 1'b1;
      end else begin
        if (clear_mrc) missing_rate_corr_flag <= 1'b0;
        if (clear_ccf) clock_corr_fail_flag <= 1'b0;
      end
    end
  end

  // Wakeup detectors, one per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_wup
    wakeup_detect u_det (
      .clk(clk),
      .sys_rst(sys_rst),
      .symbol_seen(wus_seen[ch]),
      .idle_seen(idle_seen[ch]),
      .pattern_found(wup_pulse[ch])
    );
  end

  // Wakeup status, set wins over clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeup_status_flag <= 1'b0;
      wakeup_pattern_flag_per_channel <= 2'b00;
      wakeup_status_vector <= `CSW_WSV_RST;
    end else begin
      wakeup_pattern_flag_per_channel <=
        (wakeup_pattern_flag_per_channel & ~clear_wup) | wup_pulse;
      if (poc_state == POC_WAKEUP_LISTEN && |wup_pulse) begin
        wakeup_status_flag <= 1'b1;
        wakeup_status_vector <= `CSW_WSV_RECEIVED_WUP;
      end else if (clear_wst) begin
        wakeup_status_flag <= 1'b0;
      end
    end
  end

  // One-cycle event pulse for interrupt request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_event <= 1'b0;
    end else begin
      flag_event <= (cycle_end && frame_rpt.odd_cycle && miss_term) | (|wup_pulse);
    end
  end
endmodule : clock_sync_wakeup

// File: tb/csw_chk.sv
`include "csw_map.svh"
// Watches flags, state and rate of the sync and wakeup block
module csw_chk
  import csw_pkg::*;
#(
  parameter int SYNC_MAX = `CSW_SYNC_MAX
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire csw_cfg_t cfg,
  input wire logic [1:0] wus_seen,
  input wire logic cycle_end,
  input wire logic cmd_ready,
  input wire logic clear_mrc,
  input wire logic clear_ccf,
  input wire logic clear_wst,
  input wire logic missing_rate_corr_flag,
  input wire logic clock_corr_fail_flag,
  input wire logic wakeup_status_flag,
  input wire logic [1:0] wakeup_pattern_flag_per_channel,
  input wire logic [2:0] wakeup_status_vector,
  input wire poc_state_t poc_state,
  input wire logic startup_abort,
  input wire logic [11:0] rate_correction
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  mrc_sticky_a: assert property ($fell(missing_rate_corr_flag) |-> $past(clear_mrc))
    else $error("rate flag dropped without clear");
  ccf_sticky_a: assert property ($fell(clock_corr_fail_flag) |-> $past(clear_ccf))
    else $error("fail flag dropped without clear");
  wst_sticky_a: assert property ($fell(wakeup_status_flag) |-> $past(clear_wst))
    else $error("wakeup flag dropped without clear");
  ccf_pair_a: assert property ($rose(clock_corr_fail_flag) |-> missing_rate_corr_flag)
    else $error("fail flag without rate flag");
  wup_timing_a: assert property ($rose(wakeup_pattern_flag_per_channel[0])
    |-> $past(wus_seen[0], 2) || $past(wus_seen[0], 3)) else $error("pattern without symbol");
  wakeup_ready_a: assert property ($rose(wakeup_status_flag)
    |-> poc_state == POC_READY && wakeup_status_vector == `CSW_WSV_RECEIVED_WUP)
    else $error("wakeup status not consistent");
  halt_cfg_a: assert property ($past(poc_state) == POC_NORMAL_ACTIVE
    && poc_state == POC_HALT |-> $past(cfg.allow_halt_due_to_clock)) else $error("halt not allowed");
  active_leave_a: assert property ($past(poc_state) == POC_NORMAL_ACTIVE
    && poc_state != POC_NORMAL_ACTIVE |-> $past(cycle_end) || $past(cmd_ready))
    else $error("left active state outside cycle end");
  rate_hold_a: assert property ($rose(missing_rate_corr_flag) |-> $stable(rate_correction))
    else $error("rate changed on missing term");
  abort_ready_a: assert property (startup_abort |-> poc_state == POC_READY)
    else $error("abort without ready state");
endmodule : csw_chk

// File: tb/flexray_node_model.sv
// Other cluster nodes plus cycle timing as seen by the block
module flexray_node_model
  import csw_pkg::*;
(
  input wire logic clk,
  output frame_rpt_t frame_rpt,
  output logic slot_start,
  output logic cycle_end,
  output logic [1:0] wus_seen,
  output logic [1:0] idle_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 1'b0; // A frame occupies the bus
  logic odd = 1'b0; // Parity of the cycle last closed by end_cycle
  initial begin
    frame_rpt = '0;
    {slot_start, cycle_end, wus_seen, idle_seen} = 6'h00;
  end
  // Idle bus keeps no stale frame content: fields churn every cycle
  always @(posedge clk) begin
    if (!busy) begin
      frame_rpt <= {1'b0, 2'($urandom), odd, 27'($urandom)};
    end
  end
  // One decoded frame for one cycle
  task automatic frame(input logic s, o, input logic [10:0] id, input logic [15:0] d);
    @(negedge clk);
    busy = 1'b1;
    frame_rpt = {1'b1, s, 1'b0, o, id, d};
    @(negedge clk);
    frame_rpt.valid = 1'b0;
    busy = 1'b0;
  endtask : frame
  // Strobes {slot, cycle end, symbol[1:0], idle[1:0]} for one cycle
  task automatic pulse(input logic [5:0] p);
    @(negedge clk);
    {slot_start, cycle_end, wus_seen, idle_seen} = p;
    @(negedge clk);
    {slot_start, cycle_end, wus_seen, idle_seen} = 6'h00;
  endtask : pulse
  // Closes a cycle with its parity on the report
  task automatic end_cycle(input logic o);
    odd = o;
    pulse(6'h10);
  endtask : end_cycle
endmodule : flexray_node_model

// File: tb/flexray_clock_sync_wakeup_tb_top.sv
`include "csw_map.svh"
// Drives the block, queues expectations, monitor compares
module flexray_clock_sync_wakeup_tb_top
  import csw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [22:0] v; // Expected outputs
    logic [22:0] m; // Bits compared
  } note_t;
  note_t notes[$]; // Pending expectations
  note_t n; // Note under comparison
  int error_cnt = 0;
  int n_compared = 0;
  int aborts = 0; // Abort pulses seen
  int events = 0; // Flag event pulses seen
  poc_state_t fail_state; // Expected state after repeated missing terms
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] ctl_bits; // Command, clear and strobe pulses
  logic [11:0] rate; // Expected initial rate
  logic [1:0] w; // Channel under test
  frame_rpt_t frame_rpt;
  csw_cfg_t cfg;
  logic slot_start, cycle_end, action_point, strp_seen, integrating;
  logic cmd_wakeup_listen, cmd_startup, cmd_ready, clear_mrc, clear_ccf, clear_wst;
  logic [1:0] wus_seen, idle_seen, clear_wup, wakeup_pattern_flag_per_channel;
  logic [15:0] strp_deviation;
  logic missing_rate_corr_flag, clock_corr_fail_flag, wakeup_status_flag, startup_abort;
  logic [2:0] wakeup_status_vector;
  poc_state_t poc_state;
  logic [11:0] rate_correction;
  logic [15:0] offset_correction; // Offset taken at the double-cycle end
  logic [3:0] sync_count; // Distinct sync frames this double cycle
  logic flag_event; // Interrupt request pulse
  logic [22:0] obs; // Observed outputs in note layout
  assign {action_point, strp_seen, cmd_wakeup_listen, cmd_startup, cmd_ready, clear_mrc,
    clear_ccf, clear_wst, clear_wup} = ctl_bits;
  assign obs = {missing_rate_corr_flag, clock_corr_fail_flag, wakeup_status_flag,
    wakeup_pattern_flag_per_channel, wakeup_status_vector, poc_state, rate_correction};
  initial begin
    forever #2.5 clk = ~clk;
  end
  clock_sync_wakeup u_dut (
    .clk, .sys_rst, .frame_rpt, .slot_start, .action_point, .strp_seen, .strp_deviation,
    .cycle_end, .integrating, .cfg, .wus_seen, .idle_seen, .cmd_wakeup_listen, .cmd_startup,
    .cmd_ready, .clear_mrc, .clear_ccf, .clear_wst, .clear_wup, .missing_rate_corr_flag,
    .clock_corr_fail_flag, .wakeup_status_flag, .wakeup_pattern_flag_per_channel,
    .wakeup_status_vector, .poc_state, .startup_abort, .rate_correction,
    .offset_correction, .sync_count, .flag_event
  );
  flexray_node_model u_node (.clk, .frame_rpt, .slot_start, .cycle_end, .wus_seen, .idle_seen);
  // Counts one comparison, logs it only on a mismatch
  task automatic check(input string what, input logic [22:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop;
    $display("Compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // Monitor: oldest note against the settled outputs
  always @(posedge clk) begin
    if (startup_abort === 1'b1) begin
      aborts++;
    end
    // Every flag-setting event is one request pulse
    if (flag_event === 1'b1) begin
      events++;
    end
    if (notes.size() > 0) begin
      n = notes.pop_front();
      check("outputs", n.v & n.m, obs & n.m);
    end
  end
  task automatic expect_obs(input logic [22:0] v, m);
    @(negedge clk);
    notes.push_back('{v, m});
  endtask : expect_obs
  task automatic ctl(input logic [9:0] c);
    @(negedge clk);
    ctl_bits = c;
    @(negedge clk);
    ctl_bits = 10'h000;
  endtask : ctl
  // Bounded wait for the ready state
  task automatic wait_ready;
    int k;
    for (k = 0; k < 20 && poc_state !== POC_READY; k++) begin
      @(negedge clk);
    end
    if (k == 20) begin
      error_cnt++;
      $display("Error poc_state expected %h seen %h", POC_READY, poc_state);
      report_and_stop();
    end
  endtask : wait_ready
  // Even cycle: sync then non-sync frame in one slot, late reference; odd cycle
  task automatic double_cycle(input logic pair);
    u_node.pulse(6'h20);
    u_node.frame(1'b1, 1'b0, 11'h003, 16'h0010);
    u_node.frame(1'b0, 1'b0, 11'h003, 16'h0030);
    ctl(10'h300);
    u_node.end_cycle(1'b0);
    check("sync_count", 23'd1, 23'(sync_count));
    u_node.pulse(6'h20);
    if (pair) begin
      u_node.frame(1'b1, 1'b1, 11'h003, 16'h0014);
      ctl(10'h300);
    end
    u_node.end_cycle(1'b1);
    repeat (3) @(negedge clk);
  endtask : double_cycle
  // Hang guard
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    void'($urandom(45779));
    ctl_bits = 10'h000;
    integrating = 1'b1;
    strp_deviation = 16'h0000;
    cfg = '0;
    cfg.max_without_corr_passive = 4'h2;
    cfg.max_without_corr_fatal = 4'h4;
    cfg.allow_halt_due_to_clock = 1'($urandom);
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    expect_obs(23'h00_0000, 23'h7f_ffff);
    for (int i = 0; i < 2; i++) begin
      cfg.micro_init_offset_a = (i == 0) ? 8'h00 : 8'($urandom);
      cfg.micro_init_offset_b = (i == 0) ? 8'h00 : 8'($urandom);
      rate = 12'((cfg.micro_init_offset_a > cfg.micro_init_offset_b) ?
        cfg.micro_init_offset_a : cfg.micro_init_offset_b) + 12'h001;
      ctl(10'h040);
      expect_obs({8'h00, POC_STARTUP, rate}, 23'h00_7fff);
      ctl(10'h020);
    end
    ctl(10'h040);
    double_cycle(1'b1);
    expect_obs({8'h00, POC_NORMAL_ACTIVE, 12'h004}, 23'h60_7fff);
    check("offset", 23'h00_0014, 23'(offset_correction));
    // One missing term in normal active: rate kept, passive limit not yet reached
    double_cycle(1'b0);
    expect_obs({2'b11, 6'h00, POC_NORMAL_ACTIVE, 12'h004}, 23'h60_7fff);
    ctl(10'h018);
    fail_state = cfg.allow_halt_due_to_clock ? POC_HALT : POC_NORMAL_PASSIVE;
    double_cycle(1'b0);
    expect_obs({2'b11, 6'h00, fail_state, 12'h004}, 23'h60_7fff);
    ctl(10'h020);
    wait_ready();
    aborts = 0;
    ctl(10'h040);
    double_cycle(1'b0);
    wait_ready();
    expect_obs({2'b11, 6'h00, POC_READY, 12'h000}, 23'h60_7000);
    check("aborts", 23'd1, 23'(aborts));
    ctl(10'h018);
    expect_obs(23'h00_0000, 23'h60_0000);
    for (int ch = 0; ch < 2; ch++) begin
      w = 2'b01 << ch;
      ctl(10'h080);
      u_node.pulse({2'b00, w, 2'b00});
      u_node.pulse({4'h0, w});
      u_node.pulse({2'b00, w, 2'b00});
      repeat (3) @(negedge clk);
      expect_obs({3'b001, w, `CSW_WSV_RECEIVED_WUP, POC_READY, 12'h000}, 23'h1f_f000);
      ctl(10'h004 | 10'(w));
      u_node.pulse({4'h0, w});
      u_node.pulse({2'b00, w, 2'b00});
      repeat (3) @(negedge clk);
      expect_obs(23'h00_0000, 23'h0c_0000);
      u_node.pulse({4'h0, w});
      u_node.pulse({2'b00, w, 2'b00});
      repeat (3) @(negedge clk);
      expect_obs({3'b000, w, 18'h0_0000}, 23'h0c_0000);
      ctl(10'h004 | 10'(w));
    end
    repeat (2) @(negedge clk);
    check("events", 23'd7, 23'(events));
    report_and_stop();
  end
endmodule : flexray_clock_sync_wakeup_tb_top
bind clock_sync_wakeup csw_chk #(.SYNC_MAX(SYNC_MAX)) u_chk (
  .clk, .sys_rst, .cfg, .wus_seen, .cycle_end, .cmd_ready, .clear_mrc, .clear_ccf, .clear_wst,
  .missing_rate_corr_flag, .clock_corr_fail_flag, .wakeup_status_flag,
  .wakeup_pattern_flag_per_channel, .wakeup_status_vector, .poc_state, .startup_abort,
  .rate_correction
);
